// ===== src/rrls_defines.svh
// constants for the redundant receive line selector
// assumes inclusion by bare name from the package and the design file
`ifndef RRLS_DEFINES_SVH
`define RRLS_DEFINES_SVH

`define RRLS_CLK_MHZ          200
`define RRLS_INVALID_LIMIT    2'h2
`define RRLS_CH_A             1'h0
`define RRLS_CH_B             1'h1
`define RRLS_ECHO_WAIT_NS     20000
`define RRLS_ECHO_WAIT_CYC    ((`RRLS_ECHO_WAIT_NS * `RRLS_CLK_MHZ) / 1000)
`define RRLS_ECHO_CNT_W       17

`endif

// ===== src/rrls_pkg.sv
// types for the redundant receive line selector
// assumes rrls_defines.svh is on the include path
`include "rrls_defines.svh"

package rrls_pkg;

    // health reports from the link layer, one-cycle pulses
    typedef struct packed {
        logic frameOk;
        logic frameBad;
        logic respTimeout;
        logic syncMissing;
    } rrls_health_t;

    // receive serial path, one bit with a data-valid qualifier
    typedef struct packed {
        logic valid;
        logic bit_;
    } rrls_rx_t;

    typedef enum logic [1:0] {
        RRLS_IDLE = 2'b00,
        RRLS_TX   = 2'b01,
        RRLS_ECHO = 2'b10
    } rrls_echo_t;

endpackage

// ===== src/rrls_selector.sv
// redundant receive line selector: dual transmit, one receive path, echo handling
// assumes link-layer health pulses and management commands on clk
//
// Functional notes
// - transmit drives both cables identically
// - forward receive from one cable only
// - only management command changes selected channel
// - two consecutive invalid frames flag switch
// - response timeout timer expiry flags switch
// - missing sync idle in interval flags switch
// - selected channel reported to management
// - no preferred channel after initialisation
// - echo delay raises no faults
// - own echo removed, never forwarded
// - echo never duplicates a received message
// - no-echo network: emulate echo locally
// - echo function copies input to return
// - echo detection confirms link intact
`timescale 1ns/100ps
`include "rrls_defines.svh"

module rrls_selector
    import rrls_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // transmit from the link layer
    input  wire logic         txBit,
    input  wire logic         txActive,
    // cable a and b attachment units
    input  wire logic         rxBitA,
    input  wire logic         rxBitB,
    input  wire logic         rxActA,
    input  wire logic         rxActB,
    output logic              txBitA,
    output logic              txBitB,
    output logic              txEnA,
    output logic              txEnB,
    output logic              returnA,
    output logic              returnB,
    // link layer receive, two-entry buffered
    output rrls_rx_t          rxOut,
    input  wire logic         rxReady,
    output logic              rxOverrun,
    // link-layer health reports
    input  rrls_health_t      health,
    // physical layer management
    input  wire logic         switchCmd,
    input  wire logic         echoNetwork,
    input  wire logic         echoFunction,
    output logic              switchRequest,
    output logic              selChannel,
    output logic              linkConfirmed,
    output logic              echoEmulated
);

    // ***************************************************
    // pin synchronisers
    // ***************************************************
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic [3:0] rawIn;
    logic [3:0] pin;
    assign rawIn = {rxActB, rxBitB, rxActA, rxBitA};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 4'h0;
            syncB <= 4'h0;
        end else begin
            syncA <= rawIn;
            syncB <= syncA;
        end
    end
    assign pin = syncB;

    // ***************************************************
    // transmit on both cables
    // ***************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txBitA <= 1'h1;
            txBitB <= 1'h1;
            txEnA  <= 1'h0;
            txEnB  <= 1'h0;
        end else begin
            txBitA <= txActive ? txBit : 1'h1;
            txBitB <= txActive ? txBit : 1'h1;
            txEnA  <= txActive;
            txEnB  <= txActive;
        end
    end

    // ***************************************************
    // switching conditions and selector
    // ***************************************************
    logic [1:0] invalidCnt;
    logic       condHit;

    // health pulses arrive from the link layer's own monitoring
    assign condHit = (health.frameBad && invalidCnt == (`RRLS_INVALID_LIMIT - 2'h1))
                   || health.respTimeout || health.syncMissing;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            invalidCnt <= 2'h0;
        end else if (switchCmd) begin
            invalidCnt <= 2'h0;
        end else if (health.frameOk) begin
            invalidCnt <= 2'h0;
        end else if (health.frameBad && invalidCnt != `RRLS_INVALID_LIMIT) begin
            invalidCnt <= invalidCnt + 2'h1;
        end
    end

    // request is sticky until management acts; a new hit wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            switchRequest <= 1'h0;
        end else if (condHit) begin
            switchRequest <= 1'h1;
        end else if (switchCmd) begin
            switchRequest <= 1'h0;
        end
    end

    // reset value is arbitrary; no channel is favoured afterwards
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selChannel <= `RRLS_CH_A;
        end else if (switchCmd) begin
            selChannel <= ~selChannel;
        end
    end

    // ***************************************************
    // echo tracking
    // ***************************************************
    rrls_echo_t                   echoState;
    logic [`RRLS_ECHO_CNT_W-1:0]  echoCnt;
    logic                         selAct;
    logic                         selBit;
    logic                         echoSeen;

    assign selAct = (selChannel == `RRLS_CH_B) ? pin[3] : pin[1];
    assign selBit = (selChannel == `RRLS_CH_B) ? pin[2] : pin[0];

    // while transmitting and until the echo window closes, receive is the echo
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            echoState <= RRLS_IDLE;
            echoCnt   <= '0;
            echoSeen  <= 1'h0;
        end else begin
            unique case (echoState)
                RRLS_IDLE: begin
                    if (txActive) begin
                        echoState <= RRLS_TX;
                        echoSeen  <= 1'h0;
                    end
                end
                RRLS_TX: begin
                    if (selAct) begin
                        echoSeen <= 1'h1;
                    end
                    if (!txActive) begin
                        echoState <= echoNetwork ? RRLS_ECHO : RRLS_IDLE;
                        echoCnt   <= '0;
                    end
                end
                // a late echo may start after the frame; wait until it has come and gone
                RRLS_ECHO: begin
                    if (txActive) begin
                        echoState <= RRLS_TX;
                        echoSeen  <= 1'h0;
                    end else if (!echoNetwork || (!selAct && echoSeen)) begin
                        echoState <= RRLS_IDLE;
                    end else if (echoCnt ==
                                 `RRLS_ECHO_CNT_W'(`RRLS_ECHO_WAIT_CYC - 1)) begin
                        echoState <= RRLS_IDLE;
                    end else begin
                        echoCnt  <= echoCnt + 1'b1;
                        echoSeen <= echoSeen || selAct;
                    end
                end
                default: echoState <= RRLS_IDLE;
            endcase
        end
    end

    logic echoBlank;
    assign echoBlank = (echoState != RRLS_IDLE) || txActive;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            linkConfirmed <= 1'h0;
        end else if (echoNetwork && echoState != RRLS_IDLE && selAct) begin
            linkConfirmed <= 1'h1;
        end else if (echoState == RRLS_ECHO &&
                     echoCnt == `RRLS_ECHO_CNT_W'(`RRLS_ECHO_WAIT_CYC - 1)) begin
            linkConfirmed <= 1'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            echoEmulated <= 1'h1;
        end else begin
            echoEmulated <= echoNetwork ? 1'h1 : (txActive ? txBit : 1'h1);
        end
    end

    // echo function returns each received signal; own echo is not relayed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            returnA <= 1'h1;
            returnB <= 1'h1;
        end else begin
            returnA <= (echoFunction && !echoBlank) ? pin[0] : 1'h1;
            returnB <= (echoFunction && !echoBlank) ? pin[2] : 1'h1;
        end
    end

    // ***************************************************
    // two-entry receive buffer
    // ***************************************************
    logic [1:0] bufBit;
    logic       rdPtr;
    logic       wrPtr;
    logic [1:0] count;
    logic       push;
    logic       pop;

    assign push = selAct && !echoBlank && count != 2'h2;
    assign pop  = rxOut.valid && rxReady;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bufBit <= 2'h0;
            wrPtr  <= 1'h0;
            rdPtr  <= 1'h0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                bufBit[wrPtr] <= selBit;
                wrPtr         <= ~wrPtr;
            end
            if (pop) begin
                rdPtr <= ~rdPtr;
            end
            count <= count + {1'h0, push} - {1'h0, pop};
        end
    end

    // output register refreshed from the buffer head after each move
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxOut     <= '0;
            rxOverrun <= 1'h0;
        end else begin
            rxOverrun <= selAct && !echoBlank && count == 2'h2;
            // a word pushed while the last one leaves is not in the array yet
            if (pop) begin
                if (count == 2'h2) begin
                    rxOut.valid <= 1'h1;
                    rxOut.bit_  <= bufBit[~rdPtr];
                end else if (push) begin
                    rxOut.valid <= 1'h1;
                    rxOut.bit_  <= selBit;
                end else begin
                    rxOut.valid <= 1'h0;
                end
            end else if (!rxOut.valid && count != 2'h0) begin
                rxOut.valid <= 1'h1;
                rxOut.bit_  <= bufBit[rdPtr];
            end
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    property p_txSame;
        @(posedge clk) disable iff (!rst_n)
        txActive |=> (txBitA == txBitB) && txEnA && txEnB;
    endproperty
    a_txSame: assert property (p_txSame) else $error("cables differ");

    property p_selHold;
        @(posedge clk) disable iff (!rst_n)
        !switchCmd |=> $stable(selChannel);
    endproperty
    a_selHold: assert property (p_selHold) else $error("channel moved");

    property p_selFlip;
        @(posedge clk) disable iff (!rst_n)
        switchCmd |=> selChannel != $past(selChannel);
    endproperty
    a_selFlip: assert property (p_selFlip) else $error("no flip");

    property p_twoBad;
        @(posedge clk) disable iff (!rst_n)
        (health.frameBad && !switchCmd && !health.frameOk) ##1
        (health.frameBad && !switchCmd && !health.frameOk) |=> switchRequest;
    endproperty
    a_twoBad: assert property (p_twoBad) else $error("two bad no req");

    property p_tmo;
        @(posedge clk) disable iff (!rst_n)
        (health.respTimeout || health.syncMissing) |=> switchRequest;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout no req");

    property p_okClr;
        @(posedge clk) disable iff (!rst_n)
        health.frameOk |=> invalidCnt == 2'h0;
    endproperty
    a_okClr: assert property (p_okClr) else $error("count kept");

    property p_noEcho;
        @(posedge clk) disable iff (!rst_n)
        txActive |-> !push;
    endproperty
    a_noEcho: assert property (p_noEcho) else $error("echo forwarded");

    property p_emu;
        @(posedge clk) disable iff (!rst_n)
        (!echoNetwork && txActive) |=> echoEmulated == $past(txBit);
    endproperty
    a_emu: assert property (p_emu) else $error("no emulation");

endmodule

// ===== sim/rrls_link_model.sv
// link-layer receive model: takes rxOut words, counts ones and zeros
// assumes rxOut keeps valid/ready on clk
`timescale 1ns/100ps
module rrls_link_model
    import rrls_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // receive stream
    input  rrls_rx_t  rxOut,
    input  wire logic stall,
    output logic      rxReady
);
    int ones = 0;
    int zeros = 0;
    // stalls only when the bench asks, so the buffer can fill
    assign rxReady = ~stall;
    always @(posedge clk) begin
        if (rst_n && rxOut.valid && rxReady) begin
            if (rxOut.bit_) ones++;
            else zeros++;
        end
    end
endmodule

// ===== sim/redundant_receive_line_selector_tb.sv
// bench for the receive line selector, random transmit and stalls
// assumes rrls_link_model as far-side receiver
`timescale 1ns/100ps
module redundant_receive_line_selector_tb
    import rrls_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, txBit = 1'b1, txActive = 1'b0, stall = 1'b0;
    logic rxBitA = 1'b1, rxBitB = 1'b1, rxActA = 1'b0, rxActB = 1'b0, rxReady;
    logic switchCmd = 1'b0, echoNetwork = 1'b0, echoFunction = 1'b0, sel = 1'b0;
    logic txBitA, txBitB, txEnA, txEnB, returnA, returnB, rxOverrun;
    logic switchRequest, selChannel, linkConfirmed, echoEmulated;
    rrls_rx_t     rxOut;
    rrls_health_t health = '0;
    int fails = 0, total_checks = 0, cyc = 0, o0, z0;

    rrls_selector u_dut (.clk, .rst_n, .txBit, .txActive, .rxBitA, .rxBitB, .rxActA,
        .rxActB, .txBitA, .txBitB, .txEnA, .txEnB, .returnA, .returnB, .rxOut, .rxReady,
        .rxOverrun, .health, .switchCmd, .echoNetwork, .echoFunction, .switchRequest,
        .selChannel, .linkConfirmed, .echoEmulated);
    rrls_link_model u_link (.clk, .rst_n, .rxOut, .stall, .rxReady);

    initial forever #2.5 clk = ~clk;

    // ****************
    // expectations
    // ****************
    function automatic logic [3:0] txPins(input logic b, input logic en);
        return en ? {b, b, 2'b11} : 4'b1100;
    endfunction
    function automatic logic nextSel(input logic cur, input logic cmd);
        return cmd ? ~cur : cur;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic trig(input rrls_health_t h, input logic [7:0] exp);
        @(posedge clk) health <= h;
        @(posedge clk) health <= '0;
        @(negedge clk);
        chk(switchRequest, exp);
    endtask
    task automatic command();
        @(posedge clk) switchCmd <= 1'b1;
        @(posedge clk) switchCmd <= 1'b0;
        sel = nextSel(sel, 1'b1);
        @(negedge clk);
        chk({switchRequest, selChannel}, {1'b0, sel});
    endtask
    task automatic rxPhase(input logic one);
        repeat (6) @(posedge clk);
        @(negedge clk);
        o0 = u_link.ones;
        z0 = u_link.zeros;
        // stalls make the buffer refuse; a dropped bit must not leak
        repeat (40) @(posedge clk) stall <= 1'($urandom_range(1));
        @(posedge clk) stall <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(rxOverrun, 8'h1);
        @(posedge clk) stall <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({u_link.ones > o0, u_link.zeros > z0}, {6'h0, one, ~one});
        chk(rxOverrun, 8'h0);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        void'($urandom(32'hae1a1bf8));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({txBitA, txBitB, txEnA, txEnB, returnA, returnB, selChannel, switchRequest},
            8'hCC);
        chk({echoEmulated, linkConfirmed}, 8'h2);
        for (int i = 0; i < 64; i++) begin
            logic a, b;
            a = 1'($urandom_range(1));
            b = a ? 1'($urandom_range(1)) : 1'b1;
            @(posedge clk);
            txActive <= a;
            txBit <= b;
            echoNetwork <= (i >= 56);
            @(posedge clk);
            @(negedge clk);
            chk({txBitA, txBitB, txEnA, txEnB}, txPins(b, a));
            if (a) chk(echoEmulated, (i >= 56) | b);
        end
        @(posedge clk) begin
            txActive <= 1'b0;
            echoNetwork <= 1'b0;
            rxActA <= 1'b1;
            rxActB <= 1'b1;
            rxBitB <= 1'b0;
        end
        rxPhase(~sel);
        trig(4'h4, 8'h0);
        trig(4'h8, 8'h0);
        trig(4'h4, 8'h0);
        trig(4'h4, 8'h1);
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk({switchRequest, selChannel}, {1'b1, sel});
        command();
        rxPhase(~sel);
        trig(4'h4, 8'h0);
        trig(4'h8, 8'h0);
        trig(4'h2, 8'h1);
        command();
        trig(4'h1, 8'h1);
        command();
        // bad frames reported on back-to-back cycles
        @(posedge clk) health <= 4'h4;
        @(posedge clk) health <= 4'h4;
        @(posedge clk) health <= '0;
        @(negedge clk);
        chk(switchRequest, 8'h1);
        command();
        // echo network: own frame comes back a few cycles late
        @(posedge clk) begin
            rxActA <= 1'b0;
            rxActB <= 1'b0;
            echoNetwork <= 1'b1;
        end
        repeat (6) @(posedge clk);
        @(negedge clk);
        o0 = u_link.ones + u_link.zeros;
        @(posedge clk) txActive <= 1'b1;
        repeat (4) @(posedge clk);
        rxActA <= 1'b1;
        rxActB <= 1'b1;
        repeat (20) @(posedge clk) begin
            txBit <= 1'($urandom_range(1));
            rxBitA <= txBit;
            rxBitB <= txBit;
        end
        @(posedge clk) txActive <= 1'b0;
        repeat (8) @(posedge clk);
        rxActA <= 1'b0;
        rxActB <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(8'(u_link.ones + u_link.zeros - o0), 8'h0);
        chk({linkConfirmed, switchRequest}, 8'h2);
        // echo that only starts after the frame has ended must still be dropped
        o0 = u_link.ones + u_link.zeros;
        @(posedge clk) txActive <= 1'b1;
        repeat (6) @(posedge clk);
        txActive <= 1'b0;
        repeat (12) @(posedge clk);
        rxActA <= 1'b1;
        rxActB <= 1'b1;
        repeat (6) @(posedge clk);
        rxActA <= 1'b0;
        rxActB <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk(8'(u_link.ones + u_link.zeros - o0), 8'h0);
        @(posedge clk) begin
            echoFunction <= 1'b1;
            echoNetwork <= 1'b0;
            rxActA <= 1'b1;
            rxActB <= 1'b1;
            rxBitA <= 1'b0;
            rxBitB <= 1'b1;
        end
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({returnA, returnB}, 8'h1);
        @(posedge clk) echoFunction <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({returnA, returnB}, 8'h3);
        end_sim();
    end
endmodule
